/* File: pwr_pkg.sv */
package pwr_pkg;

  // System clock period, 125 MHz
  localparam int CLK_PERIOD_PS     = 8000;

  // Least low time on the reset pin that must give a reset
  localparam int MIN_RST_PULSE_NS  = 2500;
  localparam int MIN_RST_PULSE_CYC = (MIN_RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Cycles the stopped domains get to settle before the core clock returns
  localparam int WAKE_SETTLE_CYC   = 4;

  // Sleep mode codes
  localparam int               MODE_W       = 3;
  localparam logic [MODE_W-1:0] MODE_IDLE    = 3'h0;
  localparam logic [MODE_W-1:0] MODE_ADC_NR  = 3'h1;
  localparam logic [MODE_W-1:0] MODE_PDOWN   = 3'h2;
  localparam logic [MODE_W-1:0] MODE_PSAVE   = 3'h3;
  localparam logic [MODE_W-1:0] MODE_STANDBY = 3'h6;

  // Clock enable vector: bit positions
  localparam int CE_W     = 6;
  localparam int CE_CPU   = 0;
  localparam int CE_MEM   = 1;
  localparam int CE_IO    = 2;
  localparam int CE_ASYNC = 3;
  localparam int CE_ADC   = 4;
  localparam int CE_OSC   = 5;

  // Clock enable sets per mode
  localparam logic [CE_W-1:0] CE_ALL     = 6'h3F;
  localparam logic [CE_W-1:0] CE_IDLE    = 6'h3E;
  localparam logic [CE_W-1:0] CE_ADCNR   = 6'h38;
  localparam logic [CE_W-1:0] CE_PDOWN   = 6'h00;
  localparam logic [CE_W-1:0] CE_PSAVE   = 6'h08;
  localparam logic [CE_W-1:0] CE_STANDBY = 6'h20;
  localparam logic [CE_W-1:0] CE_WAKE    = 6'h3E;

  // Port geometry and special pins
  localparam int PB_W            = 8;
  localparam int PC_W            = 7;
  localparam int PD_W            = 8;
  localparam int PB_OSC_IN_BIT   = 6;
  localparam int PB_OSC_OUT_BIT  = 7;
  localparam int PC_RST_BIT      = 6;

endpackage

/* File: rst_pin_if.sv */
`timescale 1ns/1ps
interface rst_pin_if;
  logic pin_level;
  logic pin_enable;
  logic reset_req;

  modport filt (input pin_level, input pin_enable, output reset_req);
  modport ctrl (output pin_level, output pin_enable, input reset_req);
endinterface

/* File: rst_pulse_filter.sv */
`timescale 1ns/1ps
module rst_pulse_filter #(
  parameter int MIN_CYC = pwr_pkg::MIN_RST_PULSE_CYC
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  rst_pin_if.filt   pin
);

  localparam int CW = $clog2(MIN_CYC + 1);

  // Refused at elaboration: a zero count would let any glitch reset the core
  if (MIN_CYC < 1) begin : g_bad_min_cyc
    $error("MIN_CYC must be at least 1");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          req_q;
  logic          req_d;

  // Reset asserts once the pin has been sampled low on MIN_CYC + 1 edges and holds while low
  always_comb begin
    cnt_d = cnt_q;
    req_d = req_q;
    if (!pin.pin_enable || pin.pin_level) begin
      cnt_d = '0;
      req_d = 1'b0;
    end else if (cnt_q == CW'(MIN_CYC)) begin
      req_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      req_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      req_q <= req_d;
    end
  end

  assign pin.reset_req = req_q;

endmodule

/* File: sleep_reset_ctrl.sv */
`timescale 1ns/1ps
module sleep_reset_ctrl #(
  parameter int MIN_RST_CYC = pwr_pkg::MIN_RST_PULSE_CYC,
  parameter int SETTLE_CYC  = pwr_pkg::WAKE_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                         CLK_SYS_IN,
  input  wire logic                         RST_B_IN,
  // Sleep control from the core
  input  wire logic                         SLEEP_EN_IN,
  input  wire logic [pwr_pkg::MODE_W-1:0]   SLEEP_MODE_IN,
  input  wire logic                         SLEEP_CMD_IN,
  input  wire logic                         WAKE_IRQ_IN,
  // Fuses and clock selection
  input  wire logic                         RESET_PIN_DISABLE_FUSE_IN,
  input  wire logic                         CRYSTAL_FUSE_IN,
  input  wire logic                         INT_RC_CLK_IN,
  input  wire logic                         ASYNC_TIMER_CLOCK_SELECT_IN,
  // Port data and direction from the port logic, and the reset pad level
  input  wire logic [pwr_pkg::PB_W-1:0]     PORT_B_OUT_IN,
  input  wire logic [pwr_pkg::PB_W-1:0]     PORT_B_DIR_IN,
  input  wire logic [pwr_pkg::PC_W-1:0]     PORT_C_OUT_IN,
  input  wire logic [pwr_pkg::PC_W-1:0]     PORT_C_DIR_IN,
  input  wire logic [pwr_pkg::PD_W-1:0]     PORT_D_OUT_IN,
  input  wire logic [pwr_pkg::PD_W-1:0]     PORT_D_DIR_IN,
  input  wire logic                         PAD_C6_IN,
  // Clock enables and status
  output logic      [pwr_pkg::CE_W-1:0]     CLK_EN_OUT,
  output logic                              SLEEPING_OUT,
  output logic                              CORE_RESET_B_OUT,
  // Pads
  output logic      [pwr_pkg::PB_W-1:0]     PAD_B_OUT,
  output logic      [pwr_pkg::PB_W-1:0]     PAD_B_OE_B_OUT,
  output logic      [pwr_pkg::PC_W-1:0]     PAD_C_OUT,
  output logic      [pwr_pkg::PC_W-1:0]     PAD_C_OE_B_OUT,
  output logic      [pwr_pkg::PD_W-1:0]     PAD_D_OUT,
  output logic      [pwr_pkg::PD_W-1:0]     PAD_D_OE_B_OUT,
  // Pin function selects
  output logic                              CRYSTAL_PINS_SEL_OUT,
  output logic                              TIMER_OSC_PINS_SEL_OUT,
  output logic                              RESET_PIN_SEL_OUT
);

  localparam int SW = $clog2(SETTLE_CYC + 1);

  // Refused at elaboration: the counters need at least one cycle
  if (SETTLE_CYC < 1) begin : g_bad_settle
    $error("SETTLE_CYC must be at least 1");
  end
  if (MIN_RST_CYC < 1) begin : g_bad_min_rst
    $error("MIN_RST_CYC must be at least 1");
  end

  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} state_t;

  // Reset pin filter
  rst_pin_if rpin ();
  assign rpin.pin_level  = PAD_C6_IN;
  assign rpin.pin_enable = !RESET_PIN_DISABLE_FUSE_IN;

  rst_pulse_filter #(
    .MIN_CYC (MIN_RST_CYC)
  ) u_filt (
    .clk_in   (CLK_SYS_IN),
    .rst_b_in (RST_B_IN),
    .pin      (rpin.filt)
  );

  logic pin_rst;
  assign pin_rst = rpin.reset_req;

  // Mode decode: anything outside the five codes is refused
  function automatic logic [pwr_pkg::CE_W:0] mode_ce(input logic [pwr_pkg::MODE_W-1:0] m);
    logic [pwr_pkg::CE_W:0] r;
    r = {1'b0, pwr_pkg::CE_ALL};
    case (m)
      pwr_pkg::MODE_IDLE:    r = {1'b1, pwr_pkg::CE_IDLE};
      pwr_pkg::MODE_ADC_NR:  r = {1'b1, pwr_pkg::CE_ADCNR};
      pwr_pkg::MODE_PDOWN:   r = {1'b1, pwr_pkg::CE_PDOWN};
      pwr_pkg::MODE_PSAVE:   r = {1'b1, pwr_pkg::CE_PSAVE};
      pwr_pkg::MODE_STANDBY: r = {1'b1, pwr_pkg::CE_STANDBY};
      default:               r = {1'b0, pwr_pkg::CE_ALL};
    endcase
    return r;
  endfunction

  // Sleep sequencer
  state_t                  state_q;
  state_t                  state_d;
  logic [pwr_pkg::CE_W-1:0] ce_q;
  logic [pwr_pkg::CE_W-1:0] ce_d;
  logic [SW-1:0]           wcnt_q;
  logic [SW-1:0]           wcnt_d;
  logic [pwr_pkg::CE_W:0]  dec;

  always_comb begin
    state_d = state_q;
    ce_d    = ce_q;
    wcnt_d  = wcnt_q;
    dec     = mode_ce(SLEEP_MODE_IN);
    if (pin_rst) begin
      // A hardware reset ends any sleep at once
      state_d = ST_ACTIVE;
      ce_d    = pwr_pkg::CE_ALL;
      wcnt_d  = '0;
    end else begin
      case (state_q)
        ST_ACTIVE: begin
          if (SLEEP_CMD_IN && SLEEP_EN_IN && dec[pwr_pkg::CE_W]) begin
            state_d = ST_SLEEP;
            ce_d    = dec[pwr_pkg::CE_W-1:0];
          end
        end
        ST_SLEEP: begin
          // Register state is simply held: stopped domains keep their flops
          if (WAKE_IRQ_IN) begin
            state_d = ST_WAKE;
            ce_d    = pwr_pkg::CE_WAKE;
            wcnt_d  = '0;
          end
        end
        ST_WAKE: begin
          if (wcnt_q == SW'(SETTLE_CYC - 1)) begin
            state_d = ST_ACTIVE;
            ce_d    = pwr_pkg::CE_ALL;
            wcnt_d  = '0;
          end else begin
            wcnt_d = wcnt_q + SW'(1);
          end
        end
        default: begin
          state_d = ST_ACTIVE;
          ce_d    = pwr_pkg::CE_ALL;
          wcnt_d  = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_q <= ST_ACTIVE;
      ce_q    <= pwr_pkg::CE_ALL;
      wcnt_q  <= '0;
    end else begin
      state_q <= state_d;
      ce_q    <= ce_d;
      wcnt_q  <= wcnt_d;
    end
  end

  // Pin routing and pad drive
  logic                     xtal_sel;
  logic                     tosc_sel;
  logic                     rpin_sel;
  logic [pwr_pkg::PB_W-1:0] b_alt;
  logic [pwr_pkg::PC_W-1:0] c_alt;
  logic [pwr_pkg::PB_W-1:0] b_oe_b_d;
  logic [pwr_pkg::PC_W-1:0] c_oe_b_d;
  logic [pwr_pkg::PD_W-1:0] d_oe_b_d;

  always_comb begin
    xtal_sel = CRYSTAL_FUSE_IN && !INT_RC_CLK_IN;
    tosc_sel = INT_RC_CLK_IN && ASYNC_TIMER_CLOCK_SELECT_IN;
    rpin_sel = !RESET_PIN_DISABLE_FUSE_IN;
    b_alt = '0;
    c_alt = '0;
    b_alt[pwr_pkg::PB_OSC_IN_BIT]  = xtal_sel || tosc_sel;
    b_alt[pwr_pkg::PB_OSC_OUT_BIT] = xtal_sel || tosc_sel;
    c_alt[pwr_pkg::PC_RST_BIT]     = rpin_sel;
    // Oscillator and reset pins are never driven as general outputs while selected for that function
    b_oe_b_d = ~PORT_B_DIR_IN | b_alt;
    c_oe_b_d = ~PORT_C_DIR_IN | c_alt;
    d_oe_b_d = ~PORT_D_DIR_IN;
    if (pin_rst) begin
      b_oe_b_d = '1;
      c_oe_b_d = '1;
      d_oe_b_d = '1;
    end
  end

  // The async reset alone releases the pads with no clock running;
  // the filtered pin reset needs the clock to be counted at all.
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PAD_B_OUT              <= '0;
      PAD_B_OE_B_OUT         <= '1;
      PAD_C_OUT              <= '0;
      PAD_C_OE_B_OUT         <= '1;
      PAD_D_OUT              <= '0;
      PAD_D_OE_B_OUT         <= '1;
      CRYSTAL_PINS_SEL_OUT   <= 1'b0;
      TIMER_OSC_PINS_SEL_OUT <= 1'b0;
      RESET_PIN_SEL_OUT      <= 1'b0;
      CORE_RESET_B_OUT       <= 1'b0;
      CLK_EN_OUT             <= pwr_pkg::CE_ALL;
      SLEEPING_OUT           <= 1'b0;
    end else begin
      PAD_B_OUT              <= PORT_B_OUT_IN;
      PAD_B_OE_B_OUT         <= b_oe_b_d;
      PAD_C_OUT              <= PORT_C_OUT_IN;
      PAD_C_OE_B_OUT         <= c_oe_b_d;
      PAD_D_OUT              <= PORT_D_OUT_IN;
      PAD_D_OE_B_OUT         <= d_oe_b_d;
      CRYSTAL_PINS_SEL_OUT   <= xtal_sel;
      TIMER_OSC_PINS_SEL_OUT <= tosc_sel;
      RESET_PIN_SEL_OUT      <= rpin_sel;
      CORE_RESET_B_OUT       <= !pin_rst;
      CLK_EN_OUT             <= ce_d;
      SLEEPING_OUT           <= (state_d != ST_ACTIVE);
    end
  end

endmodule

/* File: sleep_reset_ctrl_assertions.sv */
`timescale 1ns/1ps
module sleep_reset_ctrl_assertions #(
  parameter int MIN_RST_CYC = pwr_pkg::MIN_RST_PULSE_CYC,
  parameter int SETTLE_CYC  = pwr_pkg::WAKE_SETTLE_CYC
) (
  // Clock and reset
  input wire logic                       CLK_SYS_IN,
  input wire logic                       RST_B_IN,
  // Sleep control
  input wire logic                       SLEEP_EN_IN,
  input wire logic                       SLEEP_CMD_IN,
  input wire logic                       WAKE_IRQ_IN,
  input wire logic [pwr_pkg::MODE_W-1:0] SLEEP_MODE_IN,
  // Fuses, clock selection and reset pad
  input wire logic                       RESET_PIN_DISABLE_FUSE_IN,
  input wire logic                       CRYSTAL_FUSE_IN,
  input wire logic                       INT_RC_CLK_IN,
  input wire logic                       ASYNC_TIMER_CLOCK_SELECT_IN,
  input wire logic                       PAD_C6_IN,
  // Watched outputs
  input wire logic [pwr_pkg::CE_W-1:0]   CLK_EN_OUT,
  input wire logic                       SLEEPING_OUT,
  input wire logic                       CORE_RESET_B_OUT,
  input wire logic [pwr_pkg::PB_W-1:0]   PAD_B_OE_B_OUT,
  input wire logic [pwr_pkg::PC_W-1:0]   PAD_C_OE_B_OUT,
  input wire logic [pwr_pkg::PD_W-1:0]   PAD_D_OE_B_OUT,
  input wire logic                       CRYSTAL_PINS_SEL_OUT,
  input wire logic                       TIMER_OSC_PINS_SEL_OUT,
  input wire logic                       RESET_PIN_SEL_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);
  // Low samples of an enabled reset pin before this edge; saturates so a stuck pin stays counted
  logic [15:0] low_cnt_q;
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      low_cnt_q <= 16'h0000;
    end else if (RESET_PIN_DISABLE_FUSE_IN || PAD_C6_IN) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q != 16'hFFFF) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  // A pin low at the command edge may already have a reset pending, so it is excluded
  logic go;
  assign go = SLEEP_CMD_IN && SLEEP_EN_IN && !SLEEPING_OUT && CORE_RESET_B_OUT && PAD_C6_IN;

  property p_idle; go && SLEEP_MODE_IN == 3'h0 |=> CLK_EN_OUT == 6'h3E && SLEEPING_OUT; endproperty
  a_idle: assert property (p_idle) else $error("idle clock set wrong");
  property p_adc; go && SLEEP_MODE_IN == 3'h1 |=> CLK_EN_OUT == 6'h38 && SLEEPING_OUT; endproperty
  a_adc: assert property (p_adc) else $error("converter mode clock set wrong");
  property p_pdown; go && SLEEP_MODE_IN == 3'h2 |=> CLK_EN_OUT == 6'h00 && SLEEPING_OUT; endproperty
  a_pdown: assert property (p_pdown) else $error("power-down clock set wrong");
  property p_psave; go && SLEEP_MODE_IN == 3'h3 |=> CLK_EN_OUT == 6'h08 && SLEEPING_OUT; endproperty
  a_psave: assert property (p_psave) else $error("power-save clock set wrong");
  property p_stby; go && SLEEP_MODE_IN == 3'h6 |=> CLK_EN_OUT == 6'h20 && SLEEPING_OUT; endproperty
  a_stby: assert property (p_stby) else $error("standby clock set wrong");
  property p_refuse;
    go && SLEEP_MODE_IN inside {3'h4, 3'h5, 3'h7} |=> !SLEEPING_OUT && CLK_EN_OUT == 6'h3F;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unknown mode entered sleep");
  property p_wake;
    SLEEPING_OUT && CLK_EN_OUT != 6'h3E && WAKE_IRQ_IN && PAD_C6_IN
      |=> CLK_EN_OUT == 6'h3E ##SETTLE_CYC CLK_EN_OUT == 6'h3F && !SLEEPING_OUT;
  endproperty
  a_wake: assert property (p_wake) else $error("wake sequence wrong");
  property p_stay; SLEEPING_OUT && CLK_EN_OUT == 6'h00 && !WAKE_IRQ_IN && PAD_C6_IN |=> CLK_EN_OUT == 6'h00; endproperty
  a_stay: assert property (p_stay) else $error("power-down left without cause");
  property p_tri; !CORE_RESET_B_OUT |-> &PAD_B_OE_B_OUT && &PAD_C_OE_B_OUT && &PAD_D_OE_B_OUT; endproperty
  a_tri: assert property (p_tri) else $error("pads driven in reset");
  property p_pin;
    !RESET_PIN_DISABLE_FUSE_IN && !PAD_C6_IN && int'(low_cnt_q) >= MIN_RST_CYC |-> ##[1:2] !CORE_RESET_B_OUT;
  endproperty
  a_pin: assert property (p_pin) else $error("long pin low gave no reset");
  property p_sel;
    CORE_RESET_B_OUT ##1 CORE_RESET_B_OUT |-> RESET_PIN_SEL_OUT == !$past(RESET_PIN_DISABLE_FUSE_IN)
      && CRYSTAL_PINS_SEL_OUT == ($past(CRYSTAL_FUSE_IN) && !$past(INT_RC_CLK_IN))
      && TIMER_OSC_PINS_SEL_OUT == ($past(INT_RC_CLK_IN) && $past(ASYNC_TIMER_CLOCK_SELECT_IN));
  endproperty
  a_sel: assert property (p_sel) else $error("pin function select wrong");
  cover property (go && SLEEP_MODE_IN == 3'h2);
  cover property (SLEEPING_OUT && WAKE_IRQ_IN);
  cover property (!CORE_RESET_B_OUT);
endmodule

bind sleep_reset_ctrl sleep_reset_ctrl_assertions #(.MIN_RST_CYC(MIN_RST_CYC), .SETTLE_CYC(SETTLE_CYC)) chk_i (
  .CLK_SYS_IN, .RST_B_IN, .SLEEP_EN_IN, .SLEEP_CMD_IN, .WAKE_IRQ_IN, .SLEEP_MODE_IN,
  .RESET_PIN_DISABLE_FUSE_IN, .CRYSTAL_FUSE_IN, .INT_RC_CLK_IN, .ASYNC_TIMER_CLOCK_SELECT_IN,
  .PAD_C6_IN, .CLK_EN_OUT, .SLEEPING_OUT, .CORE_RESET_B_OUT, .PAD_B_OE_B_OUT, .PAD_C_OE_B_OUT, .PAD_D_OE_B_OUT,
  .CRYSTAL_PINS_SEL_OUT, .TIMER_OSC_PINS_SEL_OUT, .RESET_PIN_SEL_OUT);

/* File: rst_src_model.sv */
`timescale 1ns/1ps
module rst_src_model (
  input  wire logic clk_in,
  output logic      pad_level_out,
  output logic      wake_irq_out
);
  initial begin
    pad_level_out = 1'b1;
    wake_irq_out  = 1'b0;
  end
  // Called just after an edge; the pull-up takes the pad high on release
  task automatic pulse(input int n);
    pad_level_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    pad_level_out <= 1'b1;
  endtask
  task automatic irq();
    wake_irq_out <= 1'b1;
    @(posedge clk_in);
    wake_irq_out <= 1'b0;
  endtask
endmodule

/* File: sleep_reset_ctrl_test.sv */
`timescale 1ns/1ps
module sleep_reset_ctrl_test;
  logic       clk, rst_b, sleep_en, cmd, fuse, xtal, rc, asel, pad6, irq, slp, crst_b, xsel, tsel, rsel;
  logic [2:0] mode;
  logic [5:0] ce;
  logic [6:0] pc_o, pc_d, pc, pc_oe_b;
  logic [7:0] pb_o, pb_d, pd_o, pd_d, pb, pb_oe_b, pd, pd_oe_b;
  int         error_cnt = 0;
  int         total_checks = 0;

  sleep_reset_ctrl #(.MIN_RST_CYC(4), .SETTLE_CYC(2)) uut (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .SLEEP_EN_IN(sleep_en), .SLEEP_MODE_IN(mode), .SLEEP_CMD_IN(cmd),
    .WAKE_IRQ_IN(irq), .RESET_PIN_DISABLE_FUSE_IN(fuse), .CRYSTAL_FUSE_IN(xtal), .INT_RC_CLK_IN(rc),
    .ASYNC_TIMER_CLOCK_SELECT_IN(asel), .PORT_B_OUT_IN(pb_o), .PORT_B_DIR_IN(pb_d), .PORT_C_OUT_IN(pc_o),
    .PORT_C_DIR_IN(pc_d), .PORT_D_OUT_IN(pd_o), .PORT_D_DIR_IN(pd_d), .PAD_C6_IN(pad6), .CLK_EN_OUT(ce),
    .SLEEPING_OUT(slp), .CORE_RESET_B_OUT(crst_b), .PAD_B_OUT(pb), .PAD_B_OE_B_OUT(pb_oe_b), .PAD_C_OUT(pc),
    .PAD_C_OE_B_OUT(pc_oe_b), .PAD_D_OUT(pd), .PAD_D_OE_B_OUT(pd_oe_b), .CRYSTAL_PINS_SEL_OUT(xsel),
    .TIMER_OSC_PINS_SEL_OUT(tsel), .RESET_PIN_SEL_OUT(rsel));
  rst_src_model src (.clk_in(clk), .pad_level_out(pad6), .wake_irq_out(irq));

  always #4 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reference clock-enable set per mode code; anything unlisted stays fully awake
  function automatic logic [7:0] ce_of(input int m);
    case (m)
      0: return 8'h3E;
      1: return 8'h38;
      2: return 8'h00;
      3: return 8'h08;
      6: return 8'h20;
      default: return 8'h3F;
    endcase
  endfunction
  task automatic ports();
    @(posedge clk);
    {pb_o, pb_d, pd_o, pd_d} <= $urandom;
    {pc_o, pc_d} <= 14'($urandom);
    @(posedge clk);
    #1 chk(pd, pd_o);
    chk(pb, pb_o);
    chk({1'b0, pc}, {1'b0, pc_o});
    chk(pd_oe_b, ~pd_d);
    chk(pb_oe_b, ~pb_d | ((xtal & ~rc) | (rc & asel) ? 8'hC0 : 8'h00));
    chk({1'b0, pc_oe_b}, {1'b0, ~fuse | ~pc_d[6], ~pc_d[5:0]});
  endtask

  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    {clk, rst_b, sleep_en, cmd, fuse, xtal, rc, asel, mode} = '0;
    {pb_o, pb_d, pc_o, pc_d, pd_o, pd_d} = '0;
    void'($urandom(32'h9F47));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    sleep_en <= 1'b1;
    #1 chk(pd_oe_b, 8'hFF);
    chk(ce, 8'h3F);
    for (int m = 0; m < 8; m++) begin
      ports();
      @(posedge clk);
      mode <= 3'(m);
      cmd <= 1'b1;
      @(posedge clk);
      cmd <= 1'b0;
      #1 chk(ce, ce_of(m));
      chk(slp, ce_of(m) != 8'h3F);
      if (ce_of(m) != 8'h3F) begin
        repeat (6) @(posedge clk);
        #1 chk(ce, ce_of(m));
        @(posedge clk);
        src.irq();
        #1 chk(ce, 8'h3E);
        chk(slp, 1'b1);
        @(posedge clk);
        #1 chk(ce, 8'h3E);
        @(posedge clk);
        #1 chk(ce, 8'h3F);
        chk(slp, 1'b0);
      end
    end
    // Sleep refused while disabled, and a stray interrupt while awake changes nothing
    @(posedge clk);
    sleep_en <= 1'b0;
    cmd <= 1'b1;
    mode <= 3'h2;
    @(posedge clk);
    cmd <= 1'b0;
    src.irq();
    #1 chk(slp, 1'b0);
    chk(ce, 8'h3F);
    chk(rsel, 1'b1);
    @(posedge clk);
    src.pulse(2);
    repeat (4) @(posedge clk);
    #1 chk(crst_b, 1'b1);
    // A long pin low also ends a power-down sleep at once
    @(posedge clk);
    sleep_en <= 1'b1;
    cmd <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
    src.pulse(8);
    #1 chk(crst_b, 1'b0);
    chk(pd_oe_b, 8'hFF);
    chk(pb_oe_b, 8'hFF);
    chk({1'b0, pc_oe_b}, 8'h7F);
    chk(ce, 8'h3F);
    chk(slp, 1'b0);
    repeat (4) @(posedge clk);
    #1 chk(crst_b, 1'b1);
    @(posedge clk);
    fuse <= 1'b1;
    src.pulse(8);
    #1 chk(crst_b, 1'b1);
    chk(rsel, 1'b0);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      {xtal, rc, asel} <= 3'(k);
      @(posedge clk);
      #1 chk(xsel, k[2] & ~k[1]);
      chk(tsel, k[1] & k[0]);
    end
    ports();
    @(posedge clk);
    rst_b <= 1'b0;
    #1 chk(pb_oe_b, 8'hFF);
    chk({1'b0, pc_oe_b}, 8'h7F);
    chk(pd_oe_b, 8'hFF);
    chk(crst_b, 1'b0);
    chk(ce, 8'h3F);
    report_and_stop();
  end
endmodule
